// *** bench/pm_periph_model.sv ***
// Peripheral units driving fixed patterns onto the multiplexer
`timescale 1ns/100ps
module pm_periph_model
(
  input  wire logic       rst_n,
  output logic      [3:0] s0_out,
  output logic      [3:0] s0_oe,
  output logic      [3:0] s1_out,
  output logic      [3:0] s1_oe,
  output logic      [2:0] t1_out,
  output logic      [2:0] t1_oe,
  output logic      [1:0] t3_out,
  output logic      [1:0] t4_out
);
  // Distinct levels per unit show who owns a pin; quiet in reset
  assign s0_out = {4{rst_n}};
  assign s0_oe  = {4{rst_n}};
  assign s1_out = 4'h0;
  assign s1_oe  = {4{rst_n}};
  assign t1_out = {1'b0, rst_n, 1'b0};
  assign t1_oe  = {3{rst_n}};
  assign t3_out = {1'b0, rst_n};
  assign t4_out = 2'h0;
endmodule

// *** bench/pm_pin_mux_chk.sv ***
// Checker for pin multiplexer port behaviour
`timescale 1ns/100ps
module pm_pin_mux_chk
  import pm_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd_en,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p0_analog_en,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [4:0] p2_in,
  input wire logic [4:0] p2_oe,
  input wire logic       xosc_pins_analog,
  input wire logic       adc_ext_trigger,
  input wire logic       debug_active,
  input wire logic       debug_dd_oe,
  input wire logic       slow_clock_source_sel,
  input wire logic       radio_test_en,
  input wire logic [3:0] radio_status
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Pads lag a register write by two edges
  sequence s_adc_wr;
    sfr_wr_en && sfr_addr == PM_ADDR_ANALOG_EN ##1 !sfr_wr_en;
  endsequence
  property p_adc;
    s_adc_wr |=> p0_analog_en == $past(sfr_wdata, 2);
  endproperty
  a_adc: assert property (p_adc) else $error("analog enable");
  property p_analog_oe;
    (p0_oe & p0_analog_en) == 8'h00;
  endproperty
  a_analog_oe: assert property (p_analog_oe) else $error("analog pin driven");
  property p_radio;
    radio_test_en |=> p1_oe[7:4] == 4'hF && p1_out[7:4] == $past(radio_status);
  endproperty
  a_radio: assert property (p_radio) else $error("radio pins");
  property p_xosc;
    1'b1 |=> xosc_pins_analog == !$past(slow_clock_source_sel);
  endproperty
  a_xosc: assert property (p_xosc) else $error("crystal select");
  property p_xosc_oe;
    !slow_clock_source_sel |=> p2_oe[4:3] == 2'h0;
  endproperty
  a_xosc_oe: assert property (p_xosc_oe) else $error("crystal pins driven");
  property p_debug;
    debug_active |=> !p2_oe[PM_P2_DC] && p2_oe[PM_P2_DD] == $past(debug_dd_oe);
  endproperty
  a_debug: assert property (p_debug) else $error("debug pins");
  property p_trig;
    1'b1 |=> adc_ext_trigger == $past(p2_in[PM_P2_TRIG]);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger pin");
  property p_loc_mask;
    sfr_rd_en && sfr_addr == PM_ADDR_LOC_SEL |=> (sfr_rdata & ~PM_MASK_LOC_SEL) == 8'h00;
  endproperty
  a_loc_mask: assert property (p_loc_mask) else $error("location reserved");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pm_pin_mux pm_pin_mux_chk chk_i (.*);

// *** bench/tb_peripheral_pin_mux.sv ***
// Testbench for the peripheral pin multiplexer
`timescale 1ns/100ps
module tb_peripheral_pin_mux
  import pm_pkg::*;
;
  logic       clock = 1'b0, rst_n = 1'b0, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0, sfr_rmw = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, p0_in = 8'h5A, p1_in = 8'h00, rv;
  logic [4:0] p2_in = 5'h00;
  logic       s0_sync_mode = 1'b0, s0_flow_en = 1'b1, s1_sync_mode = 1'b0, s1_flow_en = 1'b0;
  logic       debug_active = 1'b0, debug_dd_out = 1'b0, debug_dd_oe = 1'b0;
  logic       slow_clock_source_sel = 1'b1, radio_test_en = 1'b0;
  logic [3:0] radio_status = 4'h0, s0_out, s0_oe, s1_out, s1_oe, s0_in, s1_in;
  logic [7:0] sfr_rdata, p0_out, p0_oe, p0_analog_en, p1_out, p1_oe;
  logic [4:0] p2_out, p2_oe;
  logic [2:0] t1_out, t1_oe, t1_in;
  logic [1:0] t3_out, t4_out;
  logic       xosc_pins_analog, adc_ext_trigger, debug_dd_in, debug_dc_in;
  int         failures = 0, total_checks = 0;
  always #5 clock = ~clock;
  pm_pin_mux uut (.*);
  pm_periph_model partner (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    step(1);
    {sfr_addr, sfr_wdata, sfr_wr_en} = {a, d, 1'b1};
    step(1);
    sfr_wr_en = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    step(1);
    {sfr_addr, sfr_rd_en} = {a, 1'b1};
    step(1);
    sfr_rd_en = 1'b0;
    rv = sfr_rdata;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] ra [8] = '{8'h80, 8'h90, 8'hA0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'h81};
    logic [7:0] re [8] = '{8'hFF, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    sfr_rmw = 1'b1;
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk(rv, re[i]);
    end
    sfr_rmw = 1'b0;
    rd(PM_ADDR_PORT0_LATCH);
    chk(rv, 8'h5A);
    wr(PM_ADDR_LOC_SEL, 8'hFF);
    rd(PM_ADDR_LOC_SEL);
    chk(rv, PM_MASK_LOC_SEL);
    wr(PM_ADDR_LOC_SEL, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_port0();
    logic [1:0] pr [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [3:0] ex [5] = '{4'hF, 4'h3, 4'hA, 4'hA, 4'h3};
    wr(PM_ADDR_PORT0_FSEL, 8'hFF);
    foreach (pr[i])
    begin
      s0_flow_en = (i < 4);
      wr(PM_ADDR_PORT2_DIR, {pr[i], 6'h00});
      step(2);
      chk({p0_oe[5:2], p0_out[5:2]}, {4'hF, ex[i]});
    end
    wr(PM_ADDR_ANALOG_EN, 8'h08);
    step(2);
    chk(p0_analog_en, 8'h08);
    chk(p0_oe & 8'h08, 8'h00);
    chk({s0_in, s1_in}, 8'hA6);
    chk({5'h00, t1_in}, 8'h06);
    $display("t_port0 done");
  endtask
  task automatic t_port1();
    logic [7:0] f5 [4] = '{8'h00, 8'h10, 8'h00, 8'h08};
    logic [5:0] ex [4] = '{6'h3A, 6'h38, 6'h3E, 6'h3A};
    wr(PM_ADDR_PORT1_FSEL, 8'hFF);
    wr(PM_ADDR_LOC_SEL, 8'h41);
    foreach (f5[i])
    begin
      s0_flow_en = (i > 1);
      wr(PM_ADDR_PORT2_FSEL, f5[i]);
      step(2);
      chk({2'h0, p1_oe[5:0]}, 8'h3F);
      chk({2'h0, p1_out[5:0]}, {2'h0, ex[i]});
    end
    // Serial 1 and timer 3 both at their upper location clash on 1.6 and 1.7
    wr(PM_ADDR_LOC_SEL, 8'h22);
    wr(PM_ADDR_PORT2_FSEL, 8'h00);
    step(2);
    chk({p1_oe[7:4], 2'h0, p1_out[7:6]}, 8'hC0);
    wr(PM_ADDR_PORT2_FSEL, 8'h20);
    step(2);
    chk({p1_oe[7:4], 2'h0, p1_out[7:6]}, 8'hC1);
    $display("t_port1 done");
  endtask
  task automatic t_special();
    {radio_test_en, radio_status, slow_clock_source_sel} = {1'b1, 4'hA, 1'b0};
    // Trigger pin left as plain input for the converter
    {debug_active, debug_dd_oe, debug_dd_out, p2_in} = {3'h7, 5'h05};
    step(2);
    chk({p1_oe[7:4], p1_out[7:4]}, 8'hFA);
    chk({7'h00, xosc_pins_analog}, 8'h01);
    chk({5'h00, p2_oe[2:1], p2_out[1]}, 8'h03);
    chk({5'h00, adc_ext_trigger, debug_dd_in, debug_dc_in}, 8'h05);
    debug_dd_oe = 1'b0;
    step(2);
    chk({6'h00, p2_oe[2:1]}, 8'h00);
    $display("t_special done");
  endtask
  initial
  begin
    step(8);
    rst_n = 1'b1;
    t_regs();
    t_port0();
    t_port1();
    t_special();
    finish_test();
  end
endmodule

// *** hw/pm_pin_mux.sv ***
// Pin multiplexer for ports 0 to 2 with its configuration registers
`timescale 1ns/100ps

// Notes on behaviour
// R01 - Timer 1 location bit 6 picks alternative
// R02 - Timer 3 location bit 5 picks alternative
// R03 - Timer 4 location bit 4 picks alternative
// R04 - Serial 0 location bit 0 picks alternative
// R05 - Serial 1 location bit 1 picks alternative
// R06 - Timer 1 three bidir channels; timers 3/4 two
// R07 - Port 0 priority: 00 s0, 01 s1, else timer1
// R08 - Serial 0 without flow control frees flow pins
// R09 - Serial 1 without flow control frees flow pins
// R10 - Port 1: serial 0 wins when both bits low
// R11 - Serial 0 on port 1 frees flow pins
// R12 - Port 1: serial 1 wins per its bits
// R13 - Port 1: timer 1 wins per its bits
// R14 - Port 1: timer 3 wins when its bit set
// R15 - Port 1: timer 4 wins when its bit set
// R16 - Analog enable bits make port 0 analog inputs
// R17 - Analog enable overrides port 0 function select
// R18 - Software sets trigger pin as input first
// R19 - Debug owns data and clock pins while active
// R20 - Slow clock select low gives crystal pins analog
// R21 - Radio test forces port 1 upper outputs
// R22 - Function select bit: 0 gpio, 1 peripheral
// R23 - Port 1 priority bits in port 2 select
// R24 - Port 0 priority field in port 2 direction
module pm_pin_mux
  import pm_pkg::*;
#(
  parameter int P2_PINS = 5
)
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr_en,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd_en,
  input  wire logic       sfr_rmw,
  output logic      [7:0] sfr_rdata,
  // Pads
  input  wire logic [7:0] p0_in,
  output logic      [7:0] p0_out,
  output logic      [7:0] p0_oe,
  output logic      [7:0] p0_analog_en,
  input  wire logic [7:0] p1_in,
  output logic      [7:0] p1_out,
  output logic      [7:0] p1_oe,
  input  wire logic [4:0] p2_in,
  output logic      [4:0] p2_out,
  output logic      [4:0] p2_oe,
  output logic            xosc_pins_analog,
  // Serial units
  input  wire logic       s0_sync_mode,
  input  wire logic       s0_flow_en,
  input  wire logic [3:0] s0_out,
  input  wire logic [3:0] s0_oe,
  output logic      [3:0] s0_in,
  input  wire logic       s1_sync_mode,
  input  wire logic       s1_flow_en,
  input  wire logic [3:0] s1_out,
  input  wire logic [3:0] s1_oe,
  output logic      [3:0] s1_in,
  // Timers
  input  wire logic [2:0] t1_out,
  input  wire logic [2:0] t1_oe,
  output logic      [2:0] t1_in,
  input  wire logic [1:0] t3_out,
  input  wire logic [1:0] t4_out,
  // Converter trigger, debug, clock and radio test
  output logic            adc_ext_trigger,
  input  wire logic       debug_active,
  input  wire logic       debug_dd_out,
  input  wire logic       debug_dd_oe,
  output logic            debug_dd_in,
  output logic            debug_dc_in,
  input  wire logic       slow_clock_source_sel,
  input  wire logic       radio_test_en,
  input  wire logic [3:0] radio_status
);

  if (P2_PINS != 5) begin : g_bad_p2
    $error("Port 2 must have exactly five pins");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] port0_latch_reg;
  logic [7:0] port1_latch_reg;
  logic [4:0] port2_latch_reg;
  logic [7:0] peripheral_location_select_reg;
  logic [7:0] analog_input_enable_reg;
  logic [7:0] port0_function_select_reg;
  logic [7:0] port1_function_select_reg;
  logic [7:0] port2_function_select_reg;
  logic [7:0] port0_direction_reg;
  logic [7:0] port1_direction_reg;
  logic [7:0] port2_direction_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port0_latch_reg <= PM_RST_PORT01_LATCH;
      port1_latch_reg <= PM_RST_PORT01_LATCH;
      port2_latch_reg <= PM_RST_PORT2_LATCH;
    end
    else if (sfr_wr_en)
    begin
      if (sfr_addr == PM_ADDR_PORT0_LATCH)
        port0_latch_reg <= sfr_wdata;
      if (sfr_addr == PM_ADDR_PORT1_LATCH)
        port1_latch_reg <= sfr_wdata;
      if (sfr_addr == PM_ADDR_PORT2_LATCH)
        port2_latch_reg <= sfr_wdata[4:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peripheral_location_select_reg <= PM_RST_ZERO;
      analog_input_enable_reg        <= PM_RST_ZERO;                     // [R16]
      port0_function_select_reg      <= PM_RST_ZERO;                     // [R22]
      port1_function_select_reg      <= PM_RST_ZERO;                     // [R22]
      port2_function_select_reg      <= PM_RST_ZERO;                     // [R23]
      port0_direction_reg            <= PM_RST_ZERO;
      port1_direction_reg            <= PM_RST_ZERO;
      port2_direction_reg            <= PM_RST_ZERO;                     // [R24]
    end
    else if (sfr_wr_en)
    begin
      unique case (sfr_addr)
        PM_ADDR_LOC_SEL:
          peripheral_location_select_reg <= sfr_wdata & PM_MASK_LOC_SEL;
        PM_ADDR_ANALOG_EN:   analog_input_enable_reg   <= sfr_wdata;
        PM_ADDR_PORT0_FSEL:  port0_function_select_reg <= sfr_wdata;
        PM_ADDR_PORT1_FSEL:  port1_function_select_reg <= sfr_wdata;
        PM_ADDR_PORT2_FSEL:
          port2_function_select_reg <= sfr_wdata & PM_MASK_P2_FSEL;     // [R23]
        PM_ADDR_PORT0_DIR:   port0_direction_reg <= sfr_wdata;
        PM_ADDR_PORT1_DIR:   port1_direction_reg <= sfr_wdata;
        PM_ADDR_PORT2_DIR:
          port2_direction_reg <= sfr_wdata & PM_MASK_P2_DIR;            // [R24]
        default: ;
      endcase
    end
  end

  // Ports read pin levels, except in read-modify-write where the latch is used
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata <= PM_RST_ZERO;
    else if (sfr_rd_en)
    begin
      unique case (sfr_addr)
        PM_ADDR_PORT0_LATCH: sfr_rdata <= sfr_rmw ? port0_latch_reg : p0_in;
        PM_ADDR_PORT1_LATCH: sfr_rdata <= sfr_rmw ? port1_latch_reg : p1_in;
        PM_ADDR_PORT2_LATCH:
          sfr_rdata <= {3'h0, sfr_rmw ? port2_latch_reg : p2_in};
        PM_ADDR_LOC_SEL:     sfr_rdata <= peripheral_location_select_reg;
        PM_ADDR_ANALOG_EN:   sfr_rdata <= analog_input_enable_reg;
        PM_ADDR_PORT0_FSEL:  sfr_rdata <= port0_function_select_reg;
        PM_ADDR_PORT1_FSEL:  sfr_rdata <= port1_function_select_reg;
        PM_ADDR_PORT2_FSEL:  sfr_rdata <= port2_function_select_reg;
        PM_ADDR_PORT0_DIR:   sfr_rdata <= port0_direction_reg;
        PM_ADDR_PORT1_DIR:   sfr_rdata <= port1_direction_reg;
        PM_ADDR_PORT2_DIR:   sfr_rdata <= port2_direction_reg;
        default:             sfr_rdata <= PM_RST_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority

  logic [1:0] port0_priority_sel;
  logic [3:0] port1_priority;

  assign port0_priority_sel = port2_direction_reg[PM_P0_PRI_HI:PM_P0_PRI_LO];  // [R24]
  assign port1_priority = {port2_function_select_reg[PM_BIT_S0S1_PRI],
                           port2_function_select_reg[PM_BIT_S1T3_PRI],
                           port2_function_select_reg[PM_BIT_T1T4_PRI],
                           port2_function_select_reg[PM_BIT_S0T1_PRI]};  // [R23]

  function automatic logic [1:0] pm_p0_rank(input logic [1:0] pri, input logic [2:0] u);
    logic [1:0] r;
    r = 2'h3;
    if (pri == PM_P0PRI_S0)
    begin
      if (u == 3'(PM_U_S0)) r = 2'h0;
      if (u == 3'(PM_U_S1)) r = 2'h1;
      if (u == 3'(PM_U_T1)) r = 2'h2;
    end
    else if (pri == PM_P0PRI_S1)
    begin
      if (u == 3'(PM_U_S1)) r = 2'h0;
      if (u == 3'(PM_U_S0)) r = 2'h1;
      if (u == 3'(PM_U_T1)) r = 2'h2;
    end
    else
    begin
      if (u == 3'(PM_U_T1)) r = 2'h0;
      if (u == 3'(PM_U_S0)) r = 2'h1;
      if (u == 3'(PM_U_S1)) r = 2'h2;
    end
    return r;
  endfunction

  // True when unit a takes a pin from unit b; unlisted pairs fall to index order
  function automatic logic pm_beats(input logic [1:0] port, input logic [2:0] a,
                                    input logic [2:0] b, input logic [1:0] p0,
                                    input logic [3:0] p1);
    logic w;
    w = (a < b);
    if (port == 2'h0)
      w = (pm_p0_rank(p0, a) < pm_p0_rank(p0, b));                        // [R07]
    else if (port == 2'h1)
    begin
      if (a == 3'(PM_U_S0) && b == 3'(PM_U_S1)) w = !p1[3];             // [R10]
      if (a == 3'(PM_U_S1) && b == 3'(PM_U_S0)) w = p1[3];              // [R12]
      if (a == 3'(PM_U_S1) && b == 3'(PM_U_T3)) w = !p1[2];             // [R12]
      if (a == 3'(PM_U_T3) && b == 3'(PM_U_S1)) w = p1[2];              // [R14]
      if (a == 3'(PM_U_T1) && b == 3'(PM_U_T4)) w = !p1[1];             // [R13]
      if (a == 3'(PM_U_T4) && b == 3'(PM_U_T1)) w = p1[1];              // [R15]
      if (a == 3'(PM_U_S0) && b == 3'(PM_U_T1)) w = !p1[0];             // [R10]
      if (a == 3'(PM_U_T1) && b == 3'(PM_U_S0)) w = p1[0];              // [R13]
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Claims and arbitration

  logic [PM_UNITS-1:0] claim    [3][8];
  logic [PM_UNITS-1:0] drv_out  [3][8];
  logic [PM_UNITS-1:0] drv_oe   [3][8];
  logic [7:0]          pin_in   [3];
  logic                win_v    [3][8];
  logic [2:0]          win_u    [3][8];
  logic                ok_flag;
  logic [1:0]          pt;
  logic [2:0]          pos;
  logic                use_sig;
  logic [3:0]          s0_in_next;
  logic [3:0]          s1_in_next;
  logic [2:0]          t1_in_next;

  assign pin_in[0] = p0_in;
  assign pin_in[1] = p1_in;
  assign pin_in[2] = {3'h0, p2_in};

  always_comb
  begin
    for (int p = 0; p < 3; p++)
      for (int n = 0; n < 8; n++)
      begin
        claim[p][n]   = '0;
        drv_out[p][n] = '0;
        drv_oe[p][n]  = '0;
      end
    pt         = 2'h0;
    pos        = 3'h0;
    use_sig    = 1'b0;
    s0_in_next = '0;
    s1_in_next = '0;
    t1_in_next = '0;
    for (int i = 0; i < 4; i++)
    begin
      // Flow pins are only taken in sync mode or with flow control
      use_sig = s0_sync_mode || s0_flow_en || (i < 2);                    // [R08] [R11]
      pt  = peripheral_location_select_reg[PM_BIT_S0_LOC] ? 2'h1 : 2'h0;  // [R04]
      pos = peripheral_location_select_reg[PM_BIT_S0_LOC] ?
            PM_S0_ALT2_POS[i] : PM_S0_ALT1_POS[i];                        // [R04]
      s0_in_next[i] = pin_in[pt][pos];
      claim[pt][pos][PM_U_S0]   = use_sig;
      drv_out[pt][pos][PM_U_S0] = s0_out[i];
      drv_oe[pt][pos][PM_U_S0]  = s0_oe[i];
      use_sig = s1_sync_mode || s1_flow_en || (i < 2);                    // [R09] [R12]
      pt  = peripheral_location_select_reg[PM_BIT_S1_LOC] ? 2'h1 : 2'h0;  // [R05]
      pos = peripheral_location_select_reg[PM_BIT_S1_LOC] ?
            PM_S1_ALT2_POS[i] : PM_S1_ALT1_POS[i];                        // [R05]
      s1_in_next[i] = pin_in[pt][pos];
      claim[pt][pos][PM_U_S1]   = use_sig;
      drv_out[pt][pos][PM_U_S1] = s1_out[i];
      drv_oe[pt][pos][PM_U_S1]  = s1_oe[i];
    end
    for (int i = 0; i < 3; i++)
    begin
      pt  = peripheral_location_select_reg[PM_BIT_T1_LOC] ? 2'h1 : 2'h0;  // [R01]
      pos = peripheral_location_select_reg[PM_BIT_T1_LOC] ?
            PM_T1_ALT2_POS[i] : PM_T1_ALT1_POS[i];                        // [R01]
      t1_in_next[i] = pin_in[pt][pos];                                    // [R06]
      claim[pt][pos][PM_U_T1]   = 1'b1;
      drv_out[pt][pos][PM_U_T1] = t1_out[i];
      drv_oe[pt][pos][PM_U_T1]  = t1_oe[i];                              // [R06]
    end
    for (int i = 0; i < 2; i++)
    begin
      pos = peripheral_location_select_reg[PM_BIT_T3_LOC] ?
            PM_T3_ALT2_POS[i] : PM_T3_ALT1_POS[i];                        // [R02]
      claim[1][pos][PM_U_T3]   = 1'b1;
      drv_out[1][pos][PM_U_T3] = t3_out[i];
      drv_oe[1][pos][PM_U_T3]  = 1'b1;                                    // [R06]
      pt  = peripheral_location_select_reg[PM_BIT_T4_LOC] ? 2'h2 : 2'h1;  // [R03]
      pos = peripheral_location_select_reg[PM_BIT_T4_LOC] ?
            PM_T4_ALT2_POS[i] : PM_T4_ALT1_POS[i];                        // [R03]
      claim[pt][pos][PM_U_T4]   = 1'b1;
      drv_out[pt][pos][PM_U_T4] = t4_out[i];
      drv_oe[pt][pos][PM_U_T4]  = 1'b1;                                   // [R06]
    end
  end

  always_comb
  begin
    ok_flag = 1'b0;
    for (int p = 0; p < 3; p++)
      for (int n = 0; n < 8; n++)
      begin
        win_v[p][n] = 1'b0;
        win_u[p][n] = 3'h0;
        for (int a = 0; a < PM_UNITS; a++)
          if (claim[p][n][a] && !win_v[p][n])
          begin
            ok_flag = 1'b1;
            for (int b = 0; b < PM_UNITS; b++)
              if (b != a && claim[p][n][b] &&
                  !pm_beats(2'(p), 3'(a), 3'(b), port0_priority_sel, port1_priority))
                ok_flag = 1'b0;
            if (ok_flag)
            begin
              win_v[p][n] = 1'b1;
              win_u[p][n] = 3'(a);
            end
          end
        // Cyclic priority cannot leave a pin ownerless
        if (!win_v[p][n])
          for (int a = PM_UNITS - 1; a >= 0; a--)
            if (claim[p][n][a])
            begin
              win_v[p][n] = 1'b1;
              win_u[p][n] = 3'(a);
            end
      end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin resolution and overrides

  logic [7:0] fsel     [3];
  logic [7:0] latch    [3];
  logic [7:0] dir      [3];
  logic [7:0] out_next [3];
  logic [7:0] oe_next  [3];
  logic [7:0] ana_next;

  assign fsel[0]  = port0_function_select_reg;
  assign fsel[1]  = port1_function_select_reg;
  assign fsel[2]  = {3'h0, port2_function_select_reg[2:1], 2'h0,
                     port2_function_select_reg[0]};
  assign latch[0] = port0_latch_reg;
  assign latch[1] = port1_latch_reg;
  assign latch[2] = {3'h0, port2_latch_reg};
  assign dir[0]   = port0_direction_reg;
  assign dir[1]   = port1_direction_reg;
  assign dir[2]   = {3'h0, port2_direction_reg[4:0]};

  always_comb
  begin
    ana_next = '0;
    for (int p = 0; p < 3; p++)
      for (int n = 0; n < 8; n++)
      begin
        out_next[p][n] = latch[p][n];
        oe_next[p][n]  = dir[p][n];
        if (fsel[p][n])                                                   // [R22]
        begin
          out_next[p][n] = win_v[p][n] && drv_out[p][n][win_u[p][n]];
          oe_next[p][n]  = win_v[p][n] && drv_oe[p][n][win_u[p][n]];
        end
      end
    // Analog inputs win over the function select
    for (int n = 0; n < 8; n++)
      if (analog_input_enable_reg[n])                                     // [R16] [R17]
      begin
        oe_next[0][n] = 1'b0;
        ana_next[n]   = 1'b1;
      end
    for (int n = PM_P1_TEST; n < 8; n++)
      if (radio_test_en)                                                  // [R21]
      begin
        out_next[1][n] = radio_status[n - PM_P1_TEST];
        oe_next[1][n]  = 1'b1;
      end
    if (debug_active)                                                     // [R19]
    begin
      out_next[2][PM_P2_DD] = debug_dd_out;
      oe_next[2][PM_P2_DD]  = debug_dd_oe;
      out_next[2][PM_P2_DC] = 1'b0;
      oe_next[2][PM_P2_DC]  = 1'b0;
    end
    if (!slow_clock_source_sel)                                          // [R20]
    begin
      oe_next[2][PM_P2_Q1] = 1'b0;
      oe_next[2][PM_P2_Q2] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops; pads see changes one cycle after the cause

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p0_out           <= '0;
      p0_oe            <= '0;
      p0_analog_en     <= '0;
      p1_out           <= '0;
      p1_oe            <= '0;
      p2_out           <= '0;
      p2_oe            <= '0;
      xosc_pins_analog <= 1'b0;
    end
    else
    begin
      p0_out           <= out_next[0];
      p0_oe            <= oe_next[0];
      p0_analog_en     <= ana_next;
      p1_out           <= out_next[1];
      p1_oe            <= oe_next[1];
      p2_out           <= out_next[2][4:0];
      p2_oe            <= oe_next[2][4:0];
      xosc_pins_analog <= !slow_clock_source_sel;                         // [R20]
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s0_in           <= '0;
      s1_in           <= '0;
      t1_in           <= '0;
      adc_ext_trigger <= 1'b0;
      debug_dd_in     <= 1'b0;
      debug_dc_in     <= 1'b0;
    end
    else
    begin
      s0_in           <= s0_in_next;
      s1_in           <= s1_in_next;
      t1_in           <= t1_in_next;                                      // [R06]
      // Valid only when software leaves the pin a gpio input
      adc_ext_trigger <= p2_in[PM_P2_TRIG];                               // [R18]
      debug_dd_in     <= p2_in[PM_P2_DD];
      debug_dc_in     <= p2_in[PM_P2_DC];
    end
  end

endmodule

// *** hw/pm_pkg.sv ***
// Constants for the peripheral pin multiplexer
package pm_pkg;

  // Register addresses in the special-function space
  localparam logic [7:0] PM_ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] PM_ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] PM_ADDR_PORT2_LATCH = 8'hA0;
  localparam logic [7:0] PM_ADDR_LOC_SEL     = 8'hF1;
  localparam logic [7:0] PM_ADDR_ANALOG_EN   = 8'hF2;
  localparam logic [7:0] PM_ADDR_PORT0_FSEL  = 8'hF3;
  localparam logic [7:0] PM_ADDR_PORT1_FSEL  = 8'hF4;
  localparam logic [7:0] PM_ADDR_PORT2_FSEL  = 8'hF5;
  localparam logic [7:0] PM_ADDR_PORT0_DIR   = 8'hFD;
  localparam logic [7:0] PM_ADDR_PORT1_DIR   = 8'hFE;
  localparam logic [7:0] PM_ADDR_PORT2_DIR   = 8'hFF;

  // Reset values
  localparam logic [7:0] PM_RST_PORT01_LATCH = 8'hFF;
  localparam logic [4:0] PM_RST_PORT2_LATCH  = 5'h1F;
  localparam logic [7:0] PM_RST_ZERO         = 8'h00;

  // Writable masks; other bits read as zero
  localparam logic [7:0] PM_MASK_LOC_SEL = 8'h73;
  localparam logic [7:0] PM_MASK_P2_FSEL = 8'h7F;
  localparam logic [7:0] PM_MASK_P2_DIR  = 8'hDF;

  // Field positions
  localparam int PM_BIT_T1_LOC    = 6;
  localparam int PM_BIT_T3_LOC    = 5;
  localparam int PM_BIT_T4_LOC    = 4;
  localparam int PM_BIT_S1_LOC    = 1;
  localparam int PM_BIT_S0_LOC    = 0;
  localparam int PM_BIT_S0S1_PRI  = 6;
  localparam int PM_BIT_S1T3_PRI  = 5;
  localparam int PM_BIT_T1T4_PRI  = 4;
  localparam int PM_BIT_S0T1_PRI  = 3;
  localparam int PM_P0_PRI_HI     = 7;
  localparam int PM_P0_PRI_LO     = 6;

  // Port 0 priority field values
  localparam logic [1:0] PM_P0PRI_S0 = 2'h0;
  localparam logic [1:0] PM_P0PRI_S1 = 2'h1;

  // Peripheral unit indices
  localparam int PM_U_S0   = 0;
  localparam int PM_U_S1   = 1;
  localparam int PM_U_T1   = 2;
  localparam int PM_U_T3   = 3;
  localparam int PM_U_T4   = 4;
  localparam int PM_UNITS  = 5;

  // Pin positions; serial index 0 rx/miso, 1 tx/mosi, 2 rts/sck, 3 cts/ssn
  localparam logic [3:0][2:0] PM_S0_ALT1_POS = {3'h4, 3'h5, 3'h3, 3'h2};
  localparam logic [3:0][2:0] PM_S0_ALT2_POS = {3'h2, 3'h3, 3'h5, 3'h4};
  localparam logic [3:0][2:0] PM_S1_ALT1_POS = {3'h2, 3'h3, 3'h4, 3'h5};
  localparam logic [3:0][2:0] PM_S1_ALT2_POS = {3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [2:0][2:0] PM_T1_ALT1_POS = {3'h4, 3'h3, 3'h2};
  localparam logic [2:0][2:0] PM_T1_ALT2_POS = {3'h0, 3'h1, 3'h2};
  localparam logic [1:0][2:0] PM_T3_ALT1_POS = {3'h4, 3'h3};
  localparam logic [1:0][2:0] PM_T3_ALT2_POS = {3'h7, 3'h6};
  localparam logic [1:0][2:0] PM_T4_ALT1_POS = {3'h1, 3'h0};
  localparam logic [1:0][2:0] PM_T4_ALT2_POS = {3'h3, 3'h0};

  // Fixed pins of port 2; first radio test pin of port 1
  localparam int PM_P2_TRIG = 0;
  localparam int PM_P2_DD   = 1;
  localparam int PM_P2_DC   = 2;
  localparam int PM_P2_Q1   = 3;
  localparam int PM_P2_Q2   = 4;
  localparam int PM_P1_TEST = 4;

endpackage
